/* hdl/jitter_osc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "onoff_switch_map.svh"
module jitter_osc #(
   parameter int MIN_CYC = `OSC_MIN_CYC,
   parameter int MAX_CYC = `OSC_MAX_CYC,
   parameter int STEP_CYC = `JITTER_STEP_CYC,
   parameter int DUTY_PCT = `MAX_DUTY_PCT
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // foldback stretches the period to half rate
   input wire logic slowDown,
   // outputs
   output logic cycleStart,
   output logic maxDutyWindow
);
   logic [15:0] period;
   logic [15:0] count;
   logic [15:0] stepCount;
   logic sweepUp;
   logic [15:0] effPeriod;
   logic [15:0] dutyEnd;

   assign effPeriod = slowDown ? 16'(period * 2) : period;
   assign dutyEnd = 16'((32'(period) * DUTY_PCT) / 100);

   // period counter; cycle start is a one-cycle pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= 16'h0000;
         cycleStart <= 1'b0;
      end else if (count >= effPeriod - 16'h0001) begin
         count <= 16'h0000;
         cycleStart <= 1'b1; // [RULE_01]
      end else begin
         count <= count + 16'h0001;
         cycleStart <= 1'b0;
      end
   end

   // window high for the first part of every period
   always_ff @(posedge clk) begin
      if (rst) maxDutyWindow <= 1'b0;
      else maxDutyWindow <= (count < dutyEnd); // [RULE_01]
   end

   // triangular sweep of the period, one round trip per modulation period
   always_ff @(posedge clk) begin
      if (rst) begin
         period <= 16'(MIN_CYC);
         stepCount <= 16'h0000;
         sweepUp <= 1'b1;
      end else if (stepCount >= 16'(STEP_CYC - 1)) begin
         stepCount <= 16'h0000;
         if (sweepUp) begin
            if (period >= 16'(MAX_CYC)) sweepUp <= 1'b0; // [RULE_25]
            else period <= period + 16'h0001; // [RULE_02]
         end else begin
            if (period <= 16'(MIN_CYC)) sweepUp <= 1'b1; // [RULE_25]
            else period <= period - 16'h0001; // [RULE_02]
         end
      end else begin
         stepCount <= stepCount + 16'h0001;
      end
   end
endmodule
`default_nettype wire

/* hdl/onoff_switch_cycle_controller.sv */
// Functional notes
// [RULE_01] oscillator gives cycle start and duty window
// [RULE_02] period jitters 8 kHz at 1 kHz
// [RULE_03] enable low while pin current exceeds threshold
// [RULE_04] sample enable at cycle start, switch on
// [RULE_05] enable changes ignored until next cycle
// [RULE_06] state machine scales limit from enable pattern
// [RULE_07] current limit ends pulse for the cycle
// [RULE_08] blank limit comparator after turn-on
// [RULE_09] supply lockout below 4.9 until 5.85
// [RULE_10] thermal lockout with hysteresis, auto recovery
// [RULE_11] restart counter cleared when enable pulled low
// [RULE_12] 64 ms unregulated gives 2.5 s off
// [RULE_13] restart alternates on and off while faulted
// [RULE_14] line undervoltage halts restart off counter
// [RULE_15] extension holds switch until current limit
// [RULE_16] extension inhibited until first regulation
// [RULE_17] start needs line sense above 25 uA
// [RULE_18] supply target 4.9 during line undervoltage
// [RULE_19] no line resistor disables line undervoltage
// [RULE_20] switch off at limit or window end
// [RULE_21] supply charger on only while switch off
// [RULE_22] supply overcurrent latches off until power-down
// [RULE_23] short conduction folds back frequency
// [RULE_24] faults force gate off immediately
// [RULE_25] period swept in triangular pattern
`timescale 1ns/1ps
`default_nettype none
`include "onoff_switch_map.svh"
module onoff_switch_cycle_controller #(
   parameter int AR_ON_CYCLES = `AR_ON_OSC,
   parameter int AR_OFF_CYCLES = `AR_OFF_OSC,
   parameter int BLANK_CYCLES = `BLANK_CYC,
   parameter int SHORT_ON_CYCLES = `SHORT_ON_CYC,
   parameter int OSC_MIN_CYCLES = `OSC_MIN_CYC,
   parameter int OSC_MAX_CYCLES = `OSC_MAX_CYC,
   parameter int JITTER_STEP_CYCLES = `JITTER_STEP_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // analog comparator results
   input wire onoff_switch_pkg::sense_type sense,
   // power stage
   output logic gateDrive,
   output logic chargerEnable,
   output logic supplyTargetHigh,
   // current limit level toward the limit reference
   output onoff_switch_pkg::limit_level_type limitLevel,
   // oscillator observation
   output logic cycleStart,
   output logic maxDutyWindow,
   // status
   output onoff_switch_pkg::status_type status
);
   logic enableSample;
   logic cycleActive;
   logic [7:0] onCount;
   logic lastShortOn;
   logic slowDown;
   logic supplyLock;
   logic thermalLock;
   logic ovLatch;
   logic extensionAllowed;
   logic lineUv;
   logic faultBlock;
   logic [31:0] arCount;
   logic [15:0] history;
   logic [4:0] onesCount;
   logic windowPrev;
   onoff_switch_pkg::restart_state_type arState;
   onoff_switch_pkg::restart_state_type next_arState;

   // oscillator with triangular jitter and foldback
   jitter_osc #(
      .MIN_CYC(OSC_MIN_CYCLES),
      .MAX_CYC(OSC_MAX_CYCLES),
      .STEP_CYC(JITTER_STEP_CYCLES),
      .DUTY_PCT(`MAX_DUTY_PCT)
   ) osc (
      .clk(clk),
      .rst(rst),
      .slowDown(slowDown),
      .cycleStart(cycleStart),
      .maxDutyWindow(maxDutyWindow)
   );

   // line undervoltage only counts when a sense resistor is fitted
   assign lineUv = !sense.lineSenseOk && !sense.lineResistorAbsent; // [RULE_19]

   // any of these kills the gate in the same cycle
   assign faultBlock = supplyLock || thermalLock || ovLatch || (arState != onoff_switch_pkg::AR_RUN); // [RULE_24]

   // supply undervoltage lockout; starts locked, released at full target
   always_ff @(posedge clk) begin
      if (rst) supplyLock <= 1'b1;
      else if (sense.supplyBelowLow) supplyLock <= 1'b1; // [RULE_09]
      else if (sense.supplyAtTarget && !lineUv) supplyLock <= 1'b0; // [RULE_09] [RULE_17]
   end

   // target held at the lower level while the line is low at power-up
   always_ff @(posedge clk) begin
      if (rst) supplyTargetHigh <= 1'b0;
      else supplyTargetHigh <= !lineUv; // [RULE_18]
   end

   // thermal hysteresis: set above high trip, clear only below low trip
   always_ff @(posedge clk) begin
      if (rst) thermalLock <= 1'b0;
      else if (sense.tempOverHigh) thermalLock <= 1'b1; // [RULE_10]
      else if (sense.tempBelowLow) thermalLock <= 1'b0; // [RULE_10]
   end

   // overvoltage latch; the supply falling low is the only way out
   always_ff @(posedge clk) begin
      if (rst) ovLatch <= 1'b0;
      else if (sense.supplyOverCurrent) ovLatch <= 1'b1; // [RULE_22]
      else if (sense.supplyBelowLow) ovLatch <= 1'b0; // [RULE_22]
   end

   // enable sampled only at cycle start, held for the whole cycle
   always_ff @(posedge clk) begin
      if (rst) enableSample <= 1'b0;
      else if (cycleStart) enableSample <= sense.enableHigh; // [RULE_03] [RULE_04] [RULE_05]
   end

   // enable history drives the current limit choice
   always_ff @(posedge clk) begin
      if (rst) history <= 16'hffff;
      else if (cycleStart) history <= {history[14:0], sense.enableHigh}; // [RULE_06]
   end

   // popcount of the history window
   always_comb begin
      onesCount = 5'h00;
      for (int i = 0; i < `LIM_HIST; i++) begin
         onesCount = onesCount + 5'(history[i]);
      end
   end

   // more enabled cycles means heavier load and a higher limit
   always_ff @(posedge clk) begin
      if (rst) limitLevel <= onoff_switch_pkg::LIM_FULL;
      else if (cycleStart) begin
         if (onesCount >= 5'(`LIM_HEAVY_MIN)) limitLevel <= onoff_switch_pkg::LIM_FULL; // [RULE_06]
         else if (onesCount >= 5'(`LIM_MED_MIN)) limitLevel <= onoff_switch_pkg::LIM_MED; // [RULE_06]
         else limitLevel <= onoff_switch_pkg::LIM_LOW; // [RULE_06]
      end
   end

   // extension is armed once feedback first pulls enable low
   always_ff @(posedge clk) begin
      if (rst || supplyLock) extensionAllowed <= 1'b0; // [RULE_16]
      else if (cycleStart && !sense.enableHigh) extensionAllowed <= 1'b1; // [RULE_16]
   end

   // window falling edge marks the normal end of duty
   always_ff @(posedge clk) begin
      if (rst) windowPrev <= 1'b0;
      else windowPrev <= maxDutyWindow;
   end

   // switch cycle: start on sampled enable, stop on limit or window end
   always_ff @(posedge clk) begin
      if (rst || faultBlock) cycleActive <= 1'b0; // [RULE_24]
      else if (cycleStart) cycleActive <= sense.enableHigh; // [RULE_04]
      else if (cycleActive && onCount >= 8'(BLANK_CYCLES) && sense.currentOverLimit)
         cycleActive <= 1'b0; // [RULE_07] [RULE_08] [RULE_20]
      else if (cycleActive && !maxDutyWindow && !extensionAllowed)
         cycleActive <= 1'b0; // [RULE_20] [RULE_15]
      else if (cycleActive && !maxDutyWindow && windowPrev && !enableSample)
         cycleActive <= 1'b0; // cannot happen in practice, kept for safety
   end

   // on-time counter for blanking and short-pulse detection
   always_ff @(posedge clk) begin
      if (rst || cycleStart) onCount <= 8'h00;
      else if (cycleActive && onCount != 8'hff) onCount <= onCount + 8'h01;
   end

   // a pulse shorter than the floor means startup or overload
   always_ff @(posedge clk) begin
      if (rst) lastShortOn <= 1'b0;
      else if (cycleStart && enableSample)
         lastShortOn <= (onCount < 8'(SHORT_ON_CYCLES)); // [RULE_23]
   end
   assign slowDown = lastShortOn; // [RULE_23]

   // gate follows the cycle, dropped at once by any fault
   always_comb begin
      gateDrive = cycleActive && !faultBlock; // [RULE_24] [RULE_15]
      chargerEnable = !gateDrive; // [RULE_21]
   end

   // auto-restart sequencing
   always_comb begin
      next_arState = arState;
      case (arState)
         onoff_switch_pkg::AR_RUN:
            if (cycleStart && sense.enableHigh && arCount >= 32'(AR_ON_CYCLES - 1))
               next_arState = onoff_switch_pkg::AR_OFF; // [RULE_12]
         onoff_switch_pkg::AR_OFF:
            if (lineUv) next_arState = onoff_switch_pkg::AR_WAIT_LINE; // [RULE_14]
            else if (cycleStart && arCount >= 32'(AR_OFF_CYCLES - 1))
               next_arState = onoff_switch_pkg::AR_RUN; // [RULE_13] [RULE_17]
         onoff_switch_pkg::AR_WAIT_LINE:
            if (!lineUv) next_arState = onoff_switch_pkg::AR_OFF; // [RULE_14]
         default:
            next_arState = onoff_switch_pkg::AR_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) arState <= onoff_switch_pkg::AR_RUN;
      else arState <= next_arState;
   end

   // counter runs on oscillator cycles, halted while the off phase waits for the line (not halted in run)
   always_ff @(posedge clk) begin
      if (rst || next_arState != arState && arState != onoff_switch_pkg::AR_WAIT_LINE
          && next_arState != onoff_switch_pkg::AR_WAIT_LINE)
         arCount <= 32'h00000000;
      else if (arState == onoff_switch_pkg::AR_RUN && cycleStart && !sense.enableHigh)
         arCount <= 32'h00000000; // [RULE_11]
      else if (cycleStart && arState != onoff_switch_pkg::AR_WAIT_LINE)
         arCount <= arCount + 32'h00000001; // [RULE_12] [RULE_14]
   end

   // status outputs
   always_ff @(posedge clk) begin
      if (rst) status <= '0;
      else begin
         status.supplyLockout <= supplyLock;
         status.thermalLockout <= thermalLock;
         status.overVoltLatched <= ovLatch;
         status.restartOff <= (arState != onoff_switch_pkg::AR_RUN);
         status.extensionAllowed <= extensionAllowed;
         status.lineUnderVolt <= lineUv;
      end
   end
endmodule
`default_nettype wire

/* hdl/onoff_switch_map.svh */
`ifndef ONOFF_SWITCH_MAP_SVH
`define ONOFF_SWITCH_MAP_SVH
// clock rate and oscillator figures
`define CLK_HZ 50000000
`define OSC_AVG_HZ 132000
`define JITTER_PP_HZ 8000
`define JITTER_MOD_HZ 1000
// oscillator period in clk cycles, average and jitter half-span
`define OSC_AVG_CYC (`CLK_HZ / `OSC_AVG_HZ)
`define OSC_MIN_CYC (`CLK_HZ / (`OSC_AVG_HZ + `JITTER_PP_HZ / 2))
`define OSC_MAX_CYC (`CLK_HZ / (`OSC_AVG_HZ - `JITTER_PP_HZ / 2))
// cycles per jitter sweep step (sweep up then down in one modulation period)
`define JITTER_STEPS (2 * (`OSC_MAX_CYC - `OSC_MIN_CYC))
`define JITTER_STEP_CYC (`CLK_HZ / `JITTER_MOD_HZ / `JITTER_STEPS)
// max duty window as percent of period
`define MAX_DUTY_PCT 65
// blanking interval
`define BLANK_NS 200
`define BLANK_CYC ((`BLANK_NS * 50 + 999) / 1000)
// short conduction threshold for frequency foldback
`define SHORT_ON_NS 400
`define SHORT_ON_CYC (`SHORT_ON_NS * 50 / 1000)
// auto-restart timings in oscillator cycles
`define AR_ON_MS 64
`define AR_OFF_MS 2500
`define AR_ON_OSC (`AR_ON_MS * `OSC_AVG_HZ / 1000)
`define AR_OFF_OSC (`AR_OFF_MS * `OSC_AVG_HZ / 1000)
// current limit state machine thresholds in cycles of a 16-cycle history
`define LIM_HIST 16
`define LIM_HEAVY_MIN 12
`define LIM_MED_MIN 5
`endif

/* hdl/onoff_switch_pkg.sv */
package onoff_switch_pkg;
   // current limit level chosen by the state machine
   typedef enum logic [1:0] {
      LIM_FULL = 2'b00,
      LIM_MED = 2'b01,
      LIM_LOW = 2'b10
   } limit_level_type;
   // auto-restart phase
   typedef enum logic [1:0] {
      AR_RUN = 2'b00,
      AR_OFF = 2'b01,
      AR_WAIT_LINE = 2'b10
   } restart_state_type;
   // analog comparator results
   typedef struct packed {
      logic enableHigh;
      logic currentOverLimit;
      logic lineSenseOk;
      logic lineResistorAbsent;
      logic supplyBelowLow;
      logic supplyAtTarget;
      logic supplyOverCurrent;
      logic tempOverHigh;
      logic tempBelowLow;
   } sense_type;
   // status toward the rest of the die
   typedef struct packed {
      logic supplyLockout;
      logic thermalLockout;
      logic overVoltLatched;
      logic restartOff;
      logic extensionAllowed;
      logic lineUnderVolt;
   } status_type;
endpackage

/* tb/onoff_switch_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module onoff_switch_chk #(
   parameter int OSC_MIN_CYCLES = 367,
   parameter int OSC_MAX_CYCLES = 390
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // watched ports
   input wire onoff_switch_pkg::sense_type sense,
   input wire logic gateDrive,
   input wire logic chargerEnable,
   input wire logic cycleStart,
   input wire logic maxDutyWindow,
   input wire onoff_switch_pkg::status_type status
);
   int onCnt;
   int perCnt;
   logic seen;
   logic lock;
   logic faultNow;
   // lockouts, plus raw faults that may cut a pulse inside blanking
   assign lock = status.supplyLockout | status.thermalLockout | status.overVoltLatched | status.restartOff;
   assign faultNow = lock | sense.supplyBelowLow | sense.tempOverHigh | sense.supplyOverCurrent;
   // on-time and period counters; first period after reset is partial, so not judged
   always_ff @(posedge clk) begin
      if (rst) begin
         onCnt <= 0;
         perCnt <= 0;
         seen <= 1'b0;
      end else begin
         onCnt <= gateDrive ? onCnt + 1 : 0;
         perCnt <= cycleStart ? 0 : perCnt + 1;
         seen <= seen | cycleStart;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_CHARGER: assert property (chargerEnable == !gateDrive) else $error("charger on with switch");
   AST_GATE_CAUSE: assert property ($rose(gateDrive) |-> $past(cycleStart) && $past(sense.enableHigh))
      else $error("gate rose without enabled start");
   AST_SKIP: assert property (cycleStart && !sense.enableHigh |=> !gateDrive [*8])
      else $error("skipped cycle conducted");
   AST_BLANK: assert property ($rose(gateDrive) |-> (gateDrive || faultNow) [*8])
      else $error("pulse cut in blanking");
   AST_LIMIT_OFF: assert property (gateDrive && sense.currentOverLimit && onCnt >= 12 |=> !gateDrive [*4])
      else $error("limit did not end pulse");
   AST_WIN_END: assert property ($fell(maxDutyWindow) && !status.extensionAllowed |-> ##[0:2] !gateDrive)
      else $error("pulse outlived window");
   AST_FAULT_OFF: assert property (lock |-> !gateDrive) else $error("gate on in lockout");
   AST_PERIOD: assert property (cycleStart && seen |-> perCnt + 1 inside {[OSC_MIN_CYCLES - 1:OSC_MAX_CYCLES + 1],
      [2 * OSC_MIN_CYCLES - 2:2 * OSC_MAX_CYCLES + 2]}) else $error("period out of range");
endmodule
bind onoff_switch_cycle_controller onoff_switch_chk #(.OSC_MIN_CYCLES(OSC_MIN_CYCLES),
   .OSC_MAX_CYCLES(OSC_MAX_CYCLES)) i_chk (.clk(clk), .rst(rst), .sense(sense), .gateDrive(gateDrive),
   .chargerEnable(chargerEnable), .cycleStart(cycleStart), .maxDutyWindow(maxDutyWindow), .status(status));
`default_nettype wire

/* tb/sense_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sense_model (
   // clock and switch state
   input wire logic clk,
   input wire logic gateDrive,
   input wire logic cycleStart,
   // feedback pattern and ramp length to the limit
   input wire logic [1:0] fbMode,
   input wire logic [8:0] rampLen,
   // comparator outputs
   output logic enableHigh,
   output logic currentOverLimit
);
   int level = 0;
   int onCnt = 0;
   int starts = 0;
   // output charged by pulses, drained by the load every clock
   always_ff @(posedge clk) begin
      level <= level + (gateDrive ? 8 : 0) - (level > 0 ? 1 : 0);
      onCnt <= gateDrive ? onCnt + 1 : 0;
      starts <= starts + (cycleStart ? 1 : 0);
   end
   // optocoupler pulls low past target; mode 0 changes mid-cycle on purpose
   always_comb begin
      case (fbMode)
         2'h0: enableHigh = level < 400;
         2'h1: enableHigh = 1'b1;
         2'h2: enableHigh = starts[0];
         default: enableHigh = starts[2:0] == 3'h0;
      endcase
   end
   // no current while off; a turn-on spike comes before the ramp
   assign currentOverLimit = gateDrive && (onCnt >= rampLen || onCnt < 2);
endmodule
`default_nettype wire

/* tb/tb_onoff_switch_cycle_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_onoff_switch_cycle_controller;
   localparam int AR_ON = 24;
   localparam int AR_OFF = 8;
   localparam logic [8:0] NORM = 9'h049;
   logic clk = 1'b0;
   logic rst = 1'b1;
   onoff_switch_pkg::sense_type knob = 9'h009;
   onoff_switch_pkg::sense_type sense;
   logic [1:0] fbMode = 2'h1;
   logic [8:0] rampLen = 9'h12c;
   logic enableHigh, overLimit, gateDrive, chargerEnable, targetHigh, cycleStart, maxDutyWindow, e, lk;
   onoff_switch_pkg::limit_level_type limitLevel;
   onoff_switch_pkg::status_type status;
   logic [6:0] obs;
   logic [31:0] seed = 32'h5;
   int n_mismatch = 0;
   int samples_checked = 0;
   int gap, len;
   int hi[4] = '{0, 16, 8, 2};
   always #10 clk = ~clk;
   // bench knobs with the partner's comparators laid over them
   always_comb begin
      sense = knob;
      sense.enableHigh = enableHigh;
      sense.currentOverLimit = overLimit;
   end
   assign obs = {gateDrive, status};
   onoff_switch_cycle_controller #(.AR_ON_CYCLES(AR_ON), .AR_OFF_CYCLES(AR_OFF)) i_dut (.clk(clk), .rst(rst),
      .sense(sense), .gateDrive(gateDrive), .chargerEnable(chargerEnable), .supplyTargetHigh(targetHigh),
      .limitLevel(limitLevel), .cycleStart(cycleStart), .maxDutyWindow(maxDutyWindow), .status(status));
   sense_model i_sense (.clk(clk), .gateDrive(gateDrive), .cycleStart(cycleStart), .fbMode(fbMode),
      .rampLen(rampLen), .enableHigh(enableHigh), .currentOverLimit(overLimit));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // 12 of 16 enabled starts keep full limit, 5 keep medium
   function automatic onoff_switch_pkg::limit_level_type expLevel(input int highs);
      return highs >= 12 ? onoff_switch_pkg::LIM_FULL : highs >= 5 ? onoff_switch_pkg::LIM_MED : onoff_switch_pkg::LIM_LOW;
   endfunction
   task automatic end_sim();
      if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input bit ok);
      samples_checked++;
      if (!ok) begin
         $display("ERROR %0t check %0d mismatch", $time, samples_checked);
         n_mismatch++;
      end
   endtask
   // n cycle starts seen at the falling edge; gap holds the last spacing
   task automatic waitStart(input int n);
      repeat (n) begin
         gap = 0;
         do begin
            @(negedge clk);
            gap++;
         end while (cycleStart !== 1'b1 && gap < 2000);
         if (gap >= 2000) begin
            chk(1'b0);
            end_sim();
         end
      end
   endtask
   // bounded wait for a gate or status bit; running out ends the run
   task automatic waitBit(input int b, input bit v, input int lim);
      for (int t = 0; t < lim && obs[b] !== v; t++) @(negedge clk);
      chk(obs[b] === v);
      if (obs[b] !== v) end_sim();
   endtask
   // length in clocks of the pulse after the next start
   task automatic pulse();
      waitStart(1);
      @(negedge clk);
      for (len = 0; gateDrive === 1'b1 && len < 400; len++) @(negedge clk);
   endtask
   // fault hits mid-pulse, holds after its cause goes, clears only on its own release
   task automatic faultCase(input int s, input int c, input int b);
      waitBit(6, 1'b1, 2000);
      knob[c] = 1'b0;
      knob[s] = 1'b1;
      @(negedge clk);
      chk(gateDrive === 1'b0);
      repeat (2) @(negedge clk);
      chk(status[b] === 1'b1);
      knob[s] = 1'b0;
      waitStart(2);
      chk(status[b] === 1'b1 && gateDrive === 1'b0);
      knob[c] = 1'b1;
      waitBit(b, 1'b0, 8);
      knob = NORM;
      waitBit(5, 1'b0, 40);
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      waitStart(2);
      chk(gateDrive === 1'b0 && targetHigh === 1'b0 && status.lineUnderVolt === 1'b1);
      knob = NORM;
      waitBit(5, 1'b0, 8000);
      chk(targetHigh === 1'b1);
      pulse();
      chk(len > 200 && len < 260);
      rampLen = 9'h00c;
      waitStart(2);
      len = gap;
      waitStart(1);
      chk(len > 700 || gap > 700);
      // random load: pulse comes only from an enabled start
      fbMode = 2'h0;
      for (int i = 0; i < 30; i++) begin
         seed = xorshift(seed);
         rampLen = 9'h030 + 9'(seed % 60);
         waitStart(1);
         e = enableHigh;
         lk = status.supplyLockout | status.thermalLockout | status.overVoltLatched | status.restartOff;
         @(negedge clk);
         chk(gateDrive === (e && !lk));
         chk(chargerEnable === !gateDrive);
      end
      fbMode = 2'h1;
      rampLen = 9'h12c;
      pulse();
      chk(status.extensionAllowed === 1'b1 && len > 300 && len < 304);
      for (int m = 3; m > 0; m--) begin
         fbMode = 2'(m);
         rampLen = 9'h028;
         waitStart(20);
         chk(limitLevel === expLevel(hi[m]));
      end
      fbMode = 2'h2;
      faultCase(4, 3, 5);
      faultCase(1, 0, 4);
      faultCase(2, 4, 3);
      knob = 9'h029;
      repeat (4) @(negedge clk);
      chk(status.lineUnderVolt === 1'b0);
      knob = NORM;
      // open loop: restart off period, stretched by line undervoltage
      fbMode = 2'h1;
      waitStart(AR_ON - 3);
      chk(status.restartOff === 1'b0);
      waitBit(2, 1'b1, 3200);
      knob.lineSenseOk = 1'b0;
      waitStart(AR_OFF + 4);
      chk(status.restartOff === 1'b1 && gateDrive === 1'b0);
      knob.lineSenseOk = 1'b1;
      waitBit(2, 1'b0, (AR_OFF + 2) * 800);
      waitBit(2, 1'b1, (AR_ON + 2) * 800);
      // pulses heavy enough that the feedback pulls enable low again
      rampLen = 9'h064;
      fbMode = 2'h0;
      waitBit(2, 1'b0, (AR_OFF + 2) * 800);
      waitStart(AR_ON + 4);
      chk(status.restartOff === 1'b0);
      end_sim();
   end
endmodule
`default_nettype wire
